// ==== src/pll_regs_pkg.sv ====
// Register map, field positions and reset values of the analog enable and charge pump registers.
// Assumes a 32-bit APB master; registers sit in the low 24 bits of one aligned word each.
package pll_regs_pkg;

  // Printed offsets are register indices; the byte address is four times the index.
  localparam logic [7:0] ANALOG_ENABLE_IDX = 8'h08;
  localparam logic [7:0] CHARGE_PUMP_IDX = 8'h09;
  localparam logic [11:0] ANALOG_ENABLE_ADDR = 12'h020;
  localparam logic [11:0] CHARGE_PUMP_ADDR = 12'h024;
  localparam logic [11:0] PAD_CONTROL_ADDR = 12'h03c;
  localparam int REG_WIDTH = 24;

  localparam logic [23:0] ANALOG_ENABLE_RESET = 24'hc1beff;
  localparam logic [23:0] CHARGE_PUMP_RESET = 24'h403264;
  localparam logic PAD_ALWAYS_ON_RESET = 1'h0;

  // Analog enable register fields.
  localparam int BIAS_POWER_BIT = 0;
  localparam int PUMP_POWER_BIT = 1;
  localparam int PHASE_COMPARE_POWER_BIT = 2;
  localparam int REF_BUFFER_POWER_BIT = 3;
  localparam int VCO_BUFFER_POWER_BIT = 4;
  localparam int PAD_ENABLE_BIT = 5;
  localparam int DIVIDER_CLOCK_GATE_BIT = 7;
  localparam int PRESCALER_CLOCK_BIT = 9;
  localparam int PRESCALER_BIAS_BIT = 10;
  localparam int PUMP_OPAMP_BIT = 11;
  localparam int HIGH_FREQ_REF_BIT = 21;

  // Pad control register field (the chip-wide pad policy bit).
  localparam int PAD_ALWAYS_ON_BIT = 7;

  // Charge pump register fields.
  localparam int DOWN_CURRENT_LSB = 0;
  localparam int UP_CURRENT_LSB = 7;
  localparam int OFFSET_CURRENT_LSB = 14;
  localparam int CURRENT_WIDTH = 7;
  localparam int OFFSET_UP_BIT = 21;
  localparam int OFFSET_DOWN_BIT = 22;
  localparam int HIGH_CURRENT_BIT = 23;

endpackage

// ==== src/ctrl_word_reg.sv ====
// One software-written control word with a reset value and per-byte write enables.
// Assumes the caller supplies a single-cycle write strobe in the clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module ctrl_word_reg #(
  parameter int WIDTH = 24,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Write port
  input wire logic wr_i,
  input wire logic [3:0] strb_i,
  input wire logic [31:0] wdata_i,
  // Stored value
  output logic [WIDTH-1:0] value_o
);

  // The byte strobes cover one 32-bit word, so wider registers cannot be served.
  if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
    $error("ctrl_word_reg width out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] value;
  } state_s;

  state_s state_q;
  state_s state_d;

  always_comb begin
    state_d = state_q;
    if (wr_i) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (strb_i[i / 8]) begin
          state_d.value[i] = wdata_i[i];
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q.value <= RESET_VALUE;
    end else begin
      state_q <= state_d;
    end
  end

  assign value_o = state_q.value;

endmodule
`default_nettype wire

// ==== src/sync_2ff.sv ====
// Two-stage synchroniser for a single level from outside the clk_i domain.
// Assumes the input is a slow level; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Level
  input wire logic d_i,
  output logic q_o
);

  typedef struct packed {
    logic meta;
    logic sync;
  } state_s;

  state_s state_q;
  state_s state_d;

  always_comb begin
    state_d.meta = d_i;
    state_d.sync = state_q.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= {RESET_VALUE, RESET_VALUE};
    end else begin
      state_q <= state_d;
    end
  end

  assign q_o = state_q.sync;

endmodule
`default_nettype wire

// ==== src/pll_analog_enable_and_pump_regs.sv ====
// Analog enable and charge pump configuration registers with APB access and static control outputs.
// Assumes a 25 MHz clk_i, an APB master, and an address-match level from the serial port front end.
//
// What this block does
// - Reset loads the analog enable register with c1beff.
// - Reset loads the charge pump register with 403264.
// - Bits 0..4 drive bias, pump, phase compare, reference and VCO buffer powers.
// - Pad enable low keeps the lock/serial-out pin disabled.
// - Pad enable and always-on select high drive the pin continuously.
// - Pad enable high, select low: release pin while a foreign chip address is seen.
// - Bit 7 gates the VCO divider clock into digital logic, reset 1.
// - Bit 9 enables prescaler clock, bit 10 prescaler and buffer bias, reset 1.
// - Bits 6:0 set pump down current in 20 uA steps, reset 100.
// - Bits 13:7 set pump up current in 20 uA steps, reset 100.
// - Bits 20:14 set pump offset current in 5 uA steps, reset 0.
// - Bit 23 selects high-current charge pump operation, reset 0.
`timescale 1ns/1ps
`default_nettype none
module pll_analog_enable_and_pump_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial port address match, asynchronous to clk_i
  input wire logic addr_seen_i,
  input wire logic addr_match_i,
  // Lock detect / serial out pin
  input wire logic pin_data_i,
  output logic lock_serial_out_pin_o,
  output logic lock_serial_out_pin_oe_n_o,
  // Analog enables
  output logic bias_power_o,
  output logic pump_power_o,
  output logic phase_compare_power_o,
  output logic ref_buffer_power_o,
  output logic vco_buffer_power_o,
  output logic divider_clock_gate_o,
  output logic prescaler_clock_o,
  output logic prescaler_bias_o,
  output logic pump_opamp_o,
  output logic high_freq_ref_o,
  // Charge pump settings
  output logic [6:0] pump_down_current_o,
  output logic [6:0] pump_up_current_o,
  output logic [6:0] offset_current_o,
  output logic offset_up_o,
  output logic offset_down_o,
  output logic high_current_pump_o
);

  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic pad_always_on_select;
    logic pin_out;
    logic pin_oe_n;
    logic [23:0] analog_out;
    logic [23:0] pump_out;
  } state_s;

  state_s state_q;
  state_s state_d;

  logic [23:0] analog_enable_control;
  logic [23:0] charge_pump_control;
  logic seen_sync;
  logic match_sync;
  logic pin_data_sync;
  logic setup;
  logic wr_analog;
  logic wr_pump;
  logic hit;

  // A transfer is decoded in its setup cycle and answered in the first access cycle.
  assign setup = psel && !penable && !state_q.ready;
  assign hit = (paddr == pll_regs_pkg::ANALOG_ENABLE_ADDR) || (paddr == pll_regs_pkg::CHARGE_PUMP_ADDR)
    || (paddr == pll_regs_pkg::PAD_CONTROL_ADDR);
  assign wr_analog = setup && pwrite && (paddr == pll_regs_pkg::ANALOG_ENABLE_ADDR);
  assign wr_pump = setup && pwrite && (paddr == pll_regs_pkg::CHARGE_PUMP_ADDR);

  ctrl_word_reg #(
    .WIDTH(pll_regs_pkg::REG_WIDTH),
    .RESET_VALUE(pll_regs_pkg::ANALOG_ENABLE_RESET)
  ) u_analog_reg (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_analog),
    .strb_i(pstrb),
    .wdata_i(pwdata),
    .value_o(analog_enable_control)
  );

  ctrl_word_reg #(
    .WIDTH(pll_regs_pkg::REG_WIDTH),
    .RESET_VALUE(pll_regs_pkg::CHARGE_PUMP_RESET)
  ) u_pump_reg (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_pump),
    .strb_i(pstrb),
    .wdata_i(pwdata),
    .value_o(charge_pump_control)
  );

  sync_2ff #(.RESET_VALUE(1'b0)) u_seen_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(addr_seen_i),
    .q_o(seen_sync)
  );

  sync_2ff #(.RESET_VALUE(1'b0)) u_match_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(addr_match_i),
    .q_o(match_sync)
  );

  sync_2ff #(.RESET_VALUE(1'b0)) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pin_data_i),
    .q_o(pin_data_sync)
  );

  always_comb begin
    state_d = state_q;
    state_d.ready = setup;
    state_d.slverr = 1'b0;
    if (setup) begin
      state_d.rdata = 32'h0;
      if (!hit) begin
        state_d.slverr = 1'b1;
      end else if (!pwrite) begin
        case (paddr)
          pll_regs_pkg::ANALOG_ENABLE_ADDR: state_d.rdata = {8'h00, analog_enable_control};
          pll_regs_pkg::CHARGE_PUMP_ADDR: state_d.rdata = {8'h00, charge_pump_control};
          pll_regs_pkg::PAD_CONTROL_ADDR: begin
            state_d.rdata[pll_regs_pkg::PAD_ALWAYS_ON_BIT] = state_q.pad_always_on_select;
          end
          default: state_d.rdata = 32'h0;
        endcase
      end else if (paddr == pll_regs_pkg::PAD_CONTROL_ADDR && pstrb[0]) begin
        state_d.pad_always_on_select = pwdata[pll_regs_pkg::PAD_ALWAYS_ON_BIT];
      end
    end
    // Outputs are registered copies so that every port comes from a flip-flop.
    state_d.analog_out = analog_enable_control;
    state_d.pump_out = charge_pump_control;
    state_d.pin_out = pin_data_sync;
    // Pad policy; oe_n low means the pin is driven.
    if (!analog_enable_control[pll_regs_pkg::PAD_ENABLE_BIT]) begin
      state_d.pin_oe_n = 1'b1;
    end else if (state_q.pad_always_on_select) begin
      state_d.pin_oe_n = 1'b0;
    end else begin
      state_d.pin_oe_n = seen_sync && !match_sync;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q.rdata <= 32'h0;
      state_q.ready <= 1'b0;
      state_q.slverr <= 1'b0;
      state_q.pad_always_on_select <= pll_regs_pkg::PAD_ALWAYS_ON_RESET;
      state_q.pin_out <= 1'b0;
      state_q.pin_oe_n <= 1'b1;
      state_q.analog_out <= pll_regs_pkg::ANALOG_ENABLE_RESET;
      state_q.pump_out <= pll_regs_pkg::CHARGE_PUMP_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.rdata;
  assign pready = state_q.ready;
  assign pslverr = state_q.slverr;
  assign lock_serial_out_pin_o = state_q.pin_out;
  assign lock_serial_out_pin_oe_n_o = state_q.pin_oe_n;
  assign bias_power_o = state_q.analog_out[pll_regs_pkg::BIAS_POWER_BIT];
  assign pump_power_o = state_q.analog_out[pll_regs_pkg::PUMP_POWER_BIT];
  assign phase_compare_power_o = state_q.analog_out[pll_regs_pkg::PHASE_COMPARE_POWER_BIT];
  assign ref_buffer_power_o = state_q.analog_out[pll_regs_pkg::REF_BUFFER_POWER_BIT];
  assign vco_buffer_power_o = state_q.analog_out[pll_regs_pkg::VCO_BUFFER_POWER_BIT];
  assign divider_clock_gate_o = state_q.analog_out[pll_regs_pkg::DIVIDER_CLOCK_GATE_BIT];
  assign prescaler_clock_o = state_q.analog_out[pll_regs_pkg::PRESCALER_CLOCK_BIT];
  assign prescaler_bias_o = state_q.analog_out[pll_regs_pkg::PRESCALER_BIAS_BIT];
  // Software is expected to keep this at one; hardware passes it through.
  assign pump_opamp_o = state_q.analog_out[pll_regs_pkg::PUMP_OPAMP_BIT];
  assign high_freq_ref_o = state_q.analog_out[pll_regs_pkg::HIGH_FREQ_REF_BIT];
  assign pump_down_current_o = state_q.pump_out[pll_regs_pkg::DOWN_CURRENT_LSB +: pll_regs_pkg::CURRENT_WIDTH];
  assign pump_up_current_o = state_q.pump_out[pll_regs_pkg::UP_CURRENT_LSB +: pll_regs_pkg::CURRENT_WIDTH];
  assign offset_current_o = state_q.pump_out[pll_regs_pkg::OFFSET_CURRENT_LSB +: pll_regs_pkg::CURRENT_WIDTH];
  assign offset_up_o = state_q.pump_out[pll_regs_pkg::OFFSET_UP_BIT];
  assign offset_down_o = state_q.pump_out[pll_regs_pkg::OFFSET_DOWN_BIT];
  assign high_current_pump_o = state_q.pump_out[pll_regs_pkg::HIGH_CURRENT_BIT];

endmodule
`default_nettype wire

// ==== test/pll_regs_chk.sv ====
// Checker for the APB answer and the control outputs of the register block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pll_regs_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  // Watched outputs
  input wire logic lock_serial_out_pin_oe_n_o,
  input wire logic bias_power_o,
  input wire logic [6:0] pump_down_current_o,
  input wire logic high_current_pump_o
);
  logic wr_setup;
  assign wr_setup = psel && pwrite && !penable;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_setup; psel && !penable; endsequence
  sequence s_wr_an; s_setup ##0 pwrite && pstrb == 4'hf && paddr == pll_regs_pkg::ANALOG_ENABLE_ADDR; endsequence
  sequence s_wr_cp; s_setup ##0 pwrite && pstrb == 4'hf && paddr == pll_regs_pkg::CHARGE_PUMP_ADDR; endsequence
  property p_rst; $rose(rst_n_i) |-> bias_power_o && pump_down_current_o == 7'h64 && !high_current_pump_o; endproperty
  property p_answer; s_setup |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pready |-> pslverr == !(paddr == 12'h020 || paddr == 12'h024 || paddr == 12'h03c); endproperty
  property p_pad_off; s_wr_an ##0 !pwdata[5] |=> ##1 lock_serial_out_pin_oe_n_o; endproperty
  property p_cp; s_wr_cp |=> ##1 pump_down_current_o == $past(pwdata[6:0], 2) && high_current_pump_o == $past(pwdata[23], 2); endproperty
  property p_an; s_wr_an |=> ##1 bias_power_o == $past(pwdata[0], 2); endproperty
  property p_hold; !$past(wr_setup, 2) |-> $stable(pump_down_current_o) && $stable(bias_power_o); endproperty
  a_rst: assert property (p_rst) else $error("Outputs not at reset value");
  a_answer: assert property (p_answer) else $error("No pready after setup");
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_err: assert property (p_err) else $error("pslverr wrong for address");
  a_pad_off: assert property (p_pad_off) else $error("Pin driven with pad disabled");
  a_cp: assert property (p_cp) else $error("Pump outputs do not follow write");
  a_an: assert property (p_an) else $error("Bias output does not follow write");
  a_hold: assert property (p_hold) else $error("Output changed without write");
endmodule
bind pll_analog_enable_and_pump_regs pll_regs_chk chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .lock_serial_out_pin_oe_n_o(lock_serial_out_pin_oe_n_o), .bias_power_o(bias_power_o),
  .pump_down_current_o(pump_down_current_o), .high_current_pump_o(high_current_pump_o)
);
`default_nettype wire

// ==== test/serial_front_model.sv ====
// Model of the serial bus front end reporting address frames and pin data.
// Assumes the testbench picks idle, own-address or foreign-address frames.
`timescale 1ns/1ps
`default_nettype none
module serial_front_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Frame: 0 idle, 1 own address, 2 foreign address
  input wire logic [1:0] frame_i,
  // Front end levels
  output logic addr_seen_o,
  output logic addr_match_o,
  output logic pin_data_o
);
  // Between frames the match level means nothing, so it toggles instead of holding a stale value.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_seen_o <= 1'b0;
      addr_match_o <= 1'b0;
      pin_data_o <= 1'b0;
    end else begin
      addr_seen_o <= frame_i != 2'h0;
      addr_match_o <= (frame_i == 2'h0) ? !addr_match_o : frame_i == 2'h1;
      pin_data_o <= !pin_data_o;
    end
  end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking testbench for the analog enable and charge pump registers.
// Assumes an APB slave answering with pready and the serial front end model on the pad inputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, err, seen, match, pdata, oe_n, pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic bias, pump, phase, refb, vcob, divg, psclk, psbias, opamp, hfr, offu, offd, hicp;
  logic [6:0] dn, up, offs;
  logic [1:0] frame;
  int num_errors = 0;
  int num_checks = 0;
  pll_analog_enable_and_pump_regs dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addr_seen_i(seen), .addr_match_i(match), .pin_data_i(pdata),
    .lock_serial_out_pin_o(pin), .lock_serial_out_pin_oe_n_o(oe_n), .bias_power_o(bias), .pump_power_o(pump),
    .phase_compare_power_o(phase), .ref_buffer_power_o(refb), .vco_buffer_power_o(vcob),
    .divider_clock_gate_o(divg), .prescaler_clock_o(psclk), .prescaler_bias_o(psbias), .pump_opamp_o(opamp),
    .high_freq_ref_o(hfr), .pump_down_current_o(dn), .pump_up_current_o(up), .offset_current_o(offs),
    .offset_up_o(offu), .offset_down_o(offd), .high_current_pump_o(hicp)
  );
  serial_front_model host (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .frame_i(frame), .addr_seen_o(seen), .addr_match_o(match), .pin_data_o(pdata)
  );
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Read data is taken while pready is high, then the request is released after that edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    // Only the watchdog ends a wait that never sees pready.
    while (pready !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    `CHK(rd, e)
  endtask
  task automatic test_reset();
    `CHK({bias, pump, phase, refb, vcob}, 5'h1f)
    `CHK({divg, psclk, psbias, opamp, hfr}, 5'h1e)
    `CHK({hicp, offd, offu, offs, up, dn}, 24'h403264)
    rdchk(pll_regs_pkg::ANALOG_ENABLE_ADDR, 32'h00c1beff);
    rdchk(pll_regs_pkg::CHARGE_PUMP_ADDR, 32'h00403264);
    $display("test_reset done");
  endtask
  task automatic test_write();
    wr(pll_regs_pkg::ANALOG_ENABLE_ADDR, 32'h00ea0a95);
    wr(pll_regs_pkg::CHARGE_PUMP_ADDR, 32'h009fc0ff);
    `CHK({bias, pump, phase, refb, vcob}, 5'h15)
    `CHK({divg, psclk, psbias, opamp, hfr}, 5'h1b)
    `CHK({hicp, offd, offu, offs, up, dn}, 24'h9fc0ff)
    `CHK(oe_n, 1'b1)
    rdchk(pll_regs_pkg::ANALOG_ENABLE_ADDR, 32'h00ea0a95);
    apb(1'b1, pll_regs_pkg::CHARGE_PUMP_ADDR, 32'hffffff11, 4'h1);
    rdchk(pll_regs_pkg::CHARGE_PUMP_ADDR, 32'h009fc011);
    `CHK(dn, 7'h11)
    $display("test_write done");
  endtask
  task automatic test_error();
    wr(12'h028, 32'h0);
    `CHK(err, 1'b1)
    rdchk(12'h028, 32'h0);
    `CHK(err, 1'b1)
    rdchk(pll_regs_pkg::CHARGE_PUMP_ADDR, 32'h009fc011);
    `CHK(err, 1'b0)
    $display("test_error done");
  endtask
  task automatic test_pad();
    wr(pll_regs_pkg::ANALOG_ENABLE_ADDR, 32'h00ea0ab5);
    frame <= 2'h2;
    repeat (6) @(posedge clk_i);
    `CHK(oe_n, 1'b1)
    frame <= 2'h1;
    repeat (6) @(posedge clk_i);
    `CHK(oe_n, 1'b0)
    frame <= 2'h2;
    wr(pll_regs_pkg::PAD_CONTROL_ADDR, 32'h00000080);
    rdchk(pll_regs_pkg::PAD_CONTROL_ADDR, 32'h00000080);
    repeat (6) @(posedge clk_i);
    `CHK(oe_n, 1'b0)
    // The pin data passes three flip-flops and the model toggles it every cycle.
    `CHK(pin, !pdata)
    wr(pll_regs_pkg::ANALOG_ENABLE_ADDR, 32'h00ea0a95);
    `CHK(oe_n, 1'b1)
    frame <= 2'h0;
    $display("test_pad done");
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end
  initial begin
    rst_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    frame = 2'h0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    test_reset();
    test_write();
    test_error();
    test_pad();
    end_of_test();
  end
endmodule
`default_nettype wire
